// ### logic/ceh_pkg.sv
package ceh_pkg;
  // ==========================================================
  // Error bit positions
  localparam int ERR_W = 7;
  localparam int BIT_TMO_COR = 0;
  localparam int BIT_TMO_UNC = 1;
  localparam int BIT_CABORT = 2;
  localparam int BIT_UNEXP = 3;
  localparam int BIT_UR_POST = 4;
  localparam int BIT_UR_NP = 5;
  localparam int BIT_LOG_HDR = 6;
  localparam int HDR_W = 128;
  localparam int DW_W = 32;
  localparam int MGMT_AW = 12;
  // ==========================================================
  // Management (header log) word addresses
  localparam logic [11:0] ADDR_HDR_LOG0 = 12'h81C;
  localparam logic [11:0] ADDR_HDR_LOG1 = 12'h820;
  localparam logic [11:0] ADDR_HDR_LOG2 = 12'h824;
  localparam logic [11:0] ADDR_HDR_LOG3 = 12'h828;
  // ==========================================================
  // Variant codes
  localparam logic [1:0] VAR_SOFT_X1 = 2'h0;
  localparam logic [1:0] VAR_SOFT_X4 = 2'h1;
  localparam logic [1:0] VAR_SOFT_X8 = 2'h2;
  localparam logic [1:0] VAR_HARD = 2'h3;
  // ==========================================================
  // Application register map (APB byte offsets)
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_IRQ_STAT = 8'h08;
  localparam logic [7:0] APB_IRQ_MASK = 8'h0C;
  localparam logic [7:0] APB_HDR0 = 8'h10;
  localparam logic [7:0] APB_HDR1 = 8'h14;
  localparam logic [7:0] APB_HDR2 = 8'h18;
  localparam logic [7:0] APB_HDR3 = 8'h1C;
  localparam logic [7:0] APB_ERR = 8'h20;
  // Control bits
  localparam int CTRL_PEND = 0;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_LP = 1;
  localparam int IRQ_W = 2;
endpackage

// ### logic/ceh_if.sv
`timescale 1ns/1ps
interface ceh_if;
  import ceh_pkg::*;
  logic [ERR_W-1:0] cplError;
  logic [HDR_W-1:0] errorHeaderDescriptor;
  logic cplPending;
  logic mgmtWrite;
  logic [MGMT_AW-1:0] mgmtAddr;
  logic [DW_W-1:0] mgmtData;
  logic mgmtAck;
  modport dev (
    input cplError,
    input errorHeaderDescriptor,
    input cplPending,
    input mgmtWrite,
    input mgmtAddr,
    input mgmtData,
    output mgmtAck
  );
  modport app (
    output cplError,
    output errorHeaderDescriptor,
    output cplPending,
    output mgmtWrite,
    output mgmtAddr,
    output mgmtData,
    input mgmtAck
  );
endinterface

// ### logic/ceh_device.sv
`timescale 1ns/1ps
// Summary of operation
// R01: Log header only on first error
// R02: Log flag with error bit 2..5
// R03: Soft variant: header on descriptor bus
// R04: Hard variant: four management writes first
// R05: x8 soft keeps error bits 3:1 only
// R06: Descriptor input only in x1/x4 soft
// R07: Without AER descriptor tied to zero
// R08: Dword 0 sits in top bits
// R09: Pending held while completion awaited
// R10: Low power waits for pending release
// R11: Full-featured or completer-only hard form
// R12: Each error bit pulses one cycle
// R13: Bit meanings: timeouts, abort, unexpected, UR
// R14: Descriptor stable while log flag high
module ceh_device
  import ceh_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_SOFT_X1,
  parameter bit AER_EN = 1'b1,
  parameter bit FULL_FEATURED = 1'b1
) (
  input wire logic clock,
  input wire logic srst,
  ceh_if.dev link,
  input wire logic lowPowerReq,
  output logic lowPowerActive,
  output logic [HDR_W-1:0] headerLog,
  output logic headerLogged,
  output logic [5:0] errorCount,
  output logic [ERR_W-2:0] errorSeen,
  output logic ctrlSlavePresent
);
  // ==========================================================
  // Device end of the completion-error sideband
  // Keeps a sticky record and a saturating count of error pulses,
  // captures the offending header once, and holds off low power
  // while the application still waits for completions.
  // One clock and one synchronous reset for everything below.

  // ==========================================================
  // Constants
  // Byte stride between consecutive header log words
  localparam int WORD_STEP = 4;
  // Dwords in one captured header
  localparam int HDR_WORDS = HDR_W / DW_W;
  // Lanes wired through on the x8 soft form
  localparam logic [ERR_W-1:0] ERR_MASK_X8 = ERR_W'((1 << BIT_TMO_UNC) |
    (1 << BIT_CABORT) | (1 << BIT_UNEXP));
  // Every lane on all other forms
  localparam logic [ERR_W-1:0] ERR_MASK_ALL = '1;
  // Count width is fixed by the port
  // Counter sticks at its top rather than wrapping
  localparam logic [5:0] CNT_MAX = '1;
  localparam logic [5:0] CNT_STEP = 6'h01;

  // ==========================================================
  // Decoding helpers
  // Error lanes that a variant wires through
  function automatic logic [ERR_W-1:0] errMask(input logic [1:0] v);
    // R05: x8 soft keeps bits 3:1 only
    if (v == VAR_SOFT_X8) begin
      errMask = ERR_MASK_X8;
    end else begin
      errMask = ERR_MASK_ALL;
    end
  endfunction

  // Management address selects header word w
  function automatic logic hitWord(input logic [MGMT_AW-1:0] a,
    input int w);
    hitWord = (a == ADDR_HDR_LOG0 + MGMT_AW'(WORD_STEP * w));
  endfunction

  // Any error kind that may carry a logged header
  function automatic logic hdrKind(input logic [ERR_W-1:0] e);
    hdrKind = |e[BIT_UR_NP:BIT_CABORT];
  endfunction

  // ==========================================================
  // Variant decode
  localparam logic [ERR_W-1:0] ERR_MASK = errMask(VARIANT);
  // R06: descriptor present only on x1/x4 soft
  localparam bit DESC_ON = (VARIANT == VAR_SOFT_X1) ||
                           (VARIANT == VAR_SOFT_X4);
  // Hard form takes the header over management writes
  localparam bit HARD = (VARIANT == VAR_HARD);

  // ==========================================================
  // Error lanes
  logic [ERR_W-1:0] err;
  logic logOk;
  wire logic [HDR_W-1:0] stage;
  // Missing lanes read as zero, so a stray pulse is dropped
  assign err = link.cplError & ERR_MASK;
  // R02: log request needs bits 2..5 and AER
  // Limitation: x8 soft masks the flag lane, so it never logs
  assign logOk = err[BIT_LOG_HDR] & hdrKind(err) & AER_EN;
  // R11: control slave only in the full hard form
  assign ctrlSlavePresent = HARD & FULL_FEATURED;
  // Writes land in one cycle, so the ack follows the strobe
  assign link.mgmtAck = link.mgmtWrite;

  // ==========================================================
  // Header staging (hard form)
  // R04: one staging word per management address
  for (genvar w = 0; w < HDR_WORDS; w++) begin : g_stage
    localparam int TOP = HDR_W - 1 - DW_W * w;
    logic [DW_W-1:0] word_q, word_d;
    // Soft forms never see a write, so their stage stays zero
    always_comb begin
      word_d = word_q;
      if (HARD && link.mgmtWrite && hitWord(link.mgmtAddr, w)) begin
        word_d = link.mgmtData;
      end
    end

    // Staging word register
    always_ff @(posedge clock) begin
      if (srst) begin
        word_q <= '0;
      end else begin
        word_q <= word_d;
      end
    end

    // R08: word 0 lands in the top dword
    assign stage[TOP -: DW_W] = word_q;
  end

  // ==========================================================
  // Header log
  logic [HDR_W-1:0] headerLog_d;
  logic headerLogged_d;
  // R01: capture once; later errors leave the first header
  // Flag follows the last word, so the stage is whole by then
  always_comb begin
    headerLog_d = headerLog;
    headerLogged_d = headerLogged;
    if (logOk && !headerLogged) begin
      headerLogged_d = 1'b1;
      // R06: descriptor on x1/x4 soft, staged words otherwise
      if (DESC_ON) begin
        headerLog_d = link.errorHeaderDescriptor;
      end else begin
        headerLog_d = stage;
      end
    end
  end

  // Header log registers; cleared by reset only
  always_ff @(posedge clock) begin
    if (srst) begin
      headerLog <= '0;
      headerLogged <= 1'b0;
    end else begin
      headerLog <= headerLog_d;
      headerLogged <= headerLogged_d;
    end
  end

  // ==========================================================
  // Error record
  logic [5:0] errorCount_d;
  logic [ERR_W-2:0] errorSeen_d;
  // R13: one sticky bit per error kind, flag lane left out
  always_comb begin
    errorSeen_d = errorSeen | err[ERR_W-2:0];
    errorCount_d = errorCount;
    // Several kinds in one cycle count as one event
    // Saturates so software never sees a wrap to a small count
    if (|err[ERR_W-2:0] && errorCount != CNT_MAX) begin
      errorCount_d = errorCount + CNT_STEP;
    end
  end

  // Error record registers
  always_ff @(posedge clock) begin
    if (srst) begin
      errorSeen <= '0;
      errorCount <= '0;
    end else begin
      errorSeen <= errorSeen_d;
      errorCount <= errorCount_d;
    end
  end

  // ==========================================================
  // Low-power gate
  logic lowPower_d;
  // R10: entry waits until pending drops
  always_comb begin
    lowPower_d = lowPowerActive;
    // Falls at once when the request goes away
    if (!lowPowerReq) begin
      lowPower_d = 1'b0;
    end else if (!link.cplPending) begin
      lowPower_d = 1'b1;
    end
  end

  // A pending that rises once inside does not pull the device out
  always_ff @(posedge clock) begin
    if (srst) begin
      lowPowerActive <= 1'b0;
    end else begin
      lowPowerActive <= lowPower_d;
    end
  end
endmodule

// ### logic/ceh_app.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module ceh_app
  import ceh_pkg::*;
#(
  parameter bit HARD = 1'b0,
  parameter bit AER_EN = 1'b1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  ceh_if.app link
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MGMT = 4'b0010,
    ST_FIRE = 4'b0100,
    ST_DONE = 4'b1000
  } ceh_state_t;

  ceh_state_t state_q, state_d;
  logic [31:0] hdr_q [4];
  logic [31:0] hdr_d [4];
  logic [ERR_W-1:0] errReq_q, errReq_d, cpl_d;
  logic [1:0] word_q, word_d;
  logic pend_q, pend_d;
  logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdata_d;
  logic wr, rd;
  logic rdWait_q, rdWait_d;

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  // Reads take one wait state, so prdata comes from a flop yet
  // already stands at the edge where pready is sampled high
  assign pready = ~rd | rdWait_q;
  assign pslverr = 1'b0;
  assign irq = |(stat_q & mask_q);

  // ==========================================================
  // Sequencer and registers, next values
  always_comb begin
    state_d = state_q;
    hdr_d = hdr_q;
    errReq_d = errReq_q;
    word_d = word_q;
    pend_d = pend_q;
    mask_d = mask_q;
    stat_d = stat_q;
    cpl_d = '0;
    rdata_d = 32'h0000_0000;
    rdWait_d = rd & ~rdWait_q;
    if (wr) begin
      case (paddr)
        APB_CTRL: pend_d = pwdata[CTRL_PEND];
        APB_IRQ_STAT: stat_d = stat_q & ~pwdata[IRQ_W-1:0];
        APB_IRQ_MASK: mask_d = pwdata[IRQ_W-1:0];
        APB_HDR0: hdr_d[0] = pwdata;
        APB_HDR1: hdr_d[1] = pwdata;
        APB_HDR2: hdr_d[2] = pwdata;
        APB_HDR3: hdr_d[3] = pwdata;
        APB_ERR: begin
          if (state_q == ST_IDLE) begin
            errReq_d = pwdata[ERR_W-1:0];
            word_d = 2'h0;
            // Hard form must load the log before the flag
            if (HARD && pwdata[BIT_LOG_HDR] &&
                |pwdata[BIT_UR_NP:BIT_CABORT]) begin
              state_d = ST_MGMT;
            end else begin
              state_d = ST_FIRE;
            end
          end
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (paddr)
        APB_CTRL: rdata_d = {31'h0, pend_q};
        APB_STATUS: rdata_d = {31'h0, state_q != ST_IDLE};
        APB_IRQ_STAT: rdata_d = {30'h0, stat_q};
        APB_IRQ_MASK: rdata_d = {30'h0, mask_q};
        APB_HDR0: rdata_d = hdr_q[0];
        APB_HDR1: rdata_d = hdr_q[1];
        APB_HDR2: rdata_d = hdr_q[2];
        APB_HDR3: rdata_d = hdr_q[3];
        APB_ERR: rdata_d = {25'h0, errReq_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    case (state_q)
      ST_IDLE: ;
      ST_MGMT: begin
        // Next word only once the device has taken this one
        if (link.mgmtAck) begin
          if (word_q == 2'h3) begin
            state_d = ST_FIRE;
          end
          word_d = word_q + 2'h1;
        end
      end
      ST_FIRE: begin
        cpl_d = errReq_q;
        // Flag only valid beside bits 2..5
        if (!(|errReq_q[BIT_UR_NP:BIT_CABORT])) begin
          cpl_d[BIT_LOG_HDR] = 1'b0;
        end
        state_d = ST_DONE;
      end
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // Set wins over write-one-clear
    if (state_q == ST_DONE) begin
      stat_d[IRQ_DONE] = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
      for (int i = 0; i < 4; i++) begin
        hdr_q[i] <= 32'h0000_0000;
      end
      errReq_q <= '0;
      word_q <= 2'h0;
      pend_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      prdata <= 32'h0000_0000;
      rdWait_q <= 1'b0;
      link.cplError <= '0;
    end else begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      errReq_q <= errReq_d;
      word_q <= word_d;
      pend_q <= pend_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      prdata <= rdata_d;
      rdWait_q <= rdWait_d;
      // R12: one-cycle error pulse; R02: flag with bit
      link.cplError <= cpl_d;
    end
  end

  // R03/R08/R14: dword 0 on top, stable; R07: zero without AER
  assign link.errorHeaderDescriptor = (AER_EN && !HARD) ?
    {hdr_q[0], hdr_q[1], hdr_q[2], hdr_q[3]} : '0;
  // R09: pending held by software
  assign link.cplPending = pend_q;
  // R04: four writes 0x81C..0x828 before flag
  assign link.mgmtWrite = (state_q == ST_MGMT);
  assign link.mgmtAddr = (word_q == 2'h0) ? ADDR_HDR_LOG0 :
                         (word_q == 2'h1) ? ADDR_HDR_LOG1 :
                         (word_q == 2'h2) ? ADDR_HDR_LOG2 : ADDR_HDR_LOG3;
  assign link.mgmtData = hdr_q[word_q];
endmodule

// ### tb/ceh_sva.sv
`timescale 1ns/1ps
// ====================
// Interface checks
module ceh_sva
  import ceh_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ERR_W-1:0] cplError,
  input wire logic [HDR_W-1:0] errorHeaderDescriptor,
  input wire logic cplPending,
  input wire logic mgmtWrite,
  input wire logic [MGMT_AW-1:0] mgmtAddr,
  input wire logic [DW_W-1:0] mgmtData,
  input wire logic mgmtAck
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_pulse_single: assert property (|cplError |=>
    (cplError & $past(cplError)) == '0) else $error("error bit held");
  a_flag_paired: assert property (cplError[BIT_LOG_HDR] |->
    |cplError[BIT_UR_NP:BIT_CABORT]) else $error("lone log flag");
  a_word_order: assert property (mgmtWrite && mgmtAddr == ADDR_HDR_LOG0
    |=> mgmtWrite && mgmtAddr == ADDR_HDR_LOG1
    ##1 mgmtWrite && mgmtAddr == ADDR_HDR_LOG2
    ##1 mgmtWrite && mgmtAddr == ADDR_HDR_LOG3) else $error("word order");
  a_flag_after: assert property (cplError[BIT_LOG_HDR] |->
    $past(mgmtWrite, 2) && $past(mgmtAddr, 2) == ADDR_HDR_LOG3)
    else $error("flag before header");
  a_last_flag: assert property (mgmtWrite && mgmtAddr == ADDR_HDR_LOG3
    |-> ##2 cplError[BIT_LOG_HDR]) else $error("no flag after header");
  a_addr_range: assert property (mgmtWrite |->
    mgmtAddr inside {[ADDR_HDR_LOG0:ADDR_HDR_LOG3]})
    else $error("stray address");
  a_ack_mirror: assert property (mgmtAck == mgmtWrite)
    else $error("ack mismatch");
  a_desc_idle: assert property (errorHeaderDescriptor == '0)
    else $error("descriptor driven");
  // Main scenarios reached
  c_flag: cover property (cplError[BIT_LOG_HDR]);
  c_word: cover property (mgmtWrite && mgmtData != '0);
  c_pend: cover property ($rose(cplPending));
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
// ====================
// Bench top
module testbench;
  import ceh_pkg::*;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic lowPowerReq = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, lpAct, logged, ctrlSl;
  logic [HDR_W-1:0] hlog, hdr, hlogX1;
  logic [5:0] seen, expSeen, cnt, seenX8;
  logic [HDR_W-1:0] expQ[$];
  int n_errors = 0;
  int comparisons = 0;
  ceh_if lnk();
  ceh_app #(.HARD(1'h1), .AER_EN(1'h1)) ceh_app_i (.clock(clock),
    .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(lnk));
  ceh_device #(.VARIANT(VAR_HARD)) ceh_device_i (.clock(clock),
    .srst(srst), .link(lnk), .lowPowerReq(lowPowerReq),
    .lowPowerActive(lpAct), .headerLog(hlog), .headerLogged(logged),
    .errorCount(cnt), .errorSeen(seen), .ctrlSlavePresent(ctrlSl));
  ceh_sva ceh_sva_i (.clock(clock), .srst(srst), .cplError(lnk.cplError),
    .errorHeaderDescriptor(lnk.errorHeaderDescriptor),
    .cplPending(lnk.cplPending), .mgmtWrite(lnk.mgmtWrite),
    .mgmtAddr(lnk.mgmtAddr), .mgmtData(lnk.mgmtData),
    .mgmtAck(lnk.mgmtAck));
  // Soft x1 and x8 pairs on the same register bus
  ceh_if lnkX1();
  ceh_if lnkX8();
  ceh_app #(.HARD(1'h0), .AER_EN(1'h1)) ceh_app_x1_i (.clock(clock),
    .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(),
    .pslverr(), .irq(), .link(lnkX1));
  ceh_device #(.VARIANT(VAR_SOFT_X1)) ceh_device_x1_i (.clock(clock),
    .srst(srst), .link(lnkX1), .lowPowerReq(lowPowerReq),
    .lowPowerActive(), .headerLog(hlogX1), .headerLogged(),
    .errorCount(), .errorSeen(), .ctrlSlavePresent());
  ceh_app #(.HARD(1'h0), .AER_EN(1'h1)) ceh_app_x8_i (.clock(clock),
    .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(),
    .pslverr(), .irq(), .link(lnkX8));
  ceh_device #(.VARIANT(VAR_SOFT_X8)) ceh_device_x8_i (.clock(clock),
    .srst(srst), .link(lnkX8), .lowPowerReq(lowPowerReq),
    .lowPowerActive(), .headerLog(), .headerLogged(),
    .errorCount(), .errorSeen(seenX8), .ctrlSlavePresent());
  // Clock, 20 ns period
  always #10 clock = ~clock;
  // One APB transfer; read data taken at the ready edge
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    penable <= 1'h0;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge clock);
  endtask
  task automatic chk(input string n, input logic [HDR_W-1:0] e, s);
    comparisons++;
    if (e !== s) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // Stage header words, fire error bits, wait until not busy
  task automatic fire(input logic [6:0] bits);
    for (int i = 0; i < 4; i++) begin
      apb(APB_HDR0 + 8'(4 * i), 1'h1, hdr[127 - 32 * i -: 32]);
    end
    apb(APB_ERR, 1'h1, {25'h0, bits});
    for (int i = 0; i < 40; i++) begin
      apb(APB_STATUS, 1'h0, 32'h0);
      if (rd[0] === 1'h0) break;
    end
    chk("busy", 1'h0, rd[0]);
    repeat (2) @(negedge clock);
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Logged header compared against the oldest note
  initial forever begin
    @(posedge logged);
    @(negedge clock);
    if (expQ.size() > 0) chk("headerLog", expQ.pop_front(), hlog);
  end
  // Hang guard, far beyond the expected run
  initial begin
    #200us;
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(34021));
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    apb(APB_IRQ_MASK, 1'h0, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(8'h24, 1'h1, 32'hFFFFFFFF);
    apb(8'h24, 1'h0, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("pslverr", 1'h0, pslverr);
    // First error with a header: logged, interrupt raised
    apb(APB_IRQ_MASK, 1'h1, 32'h1);
    hdr = {$urandom, $urandom, $urandom, $urandom};
    expQ.push_back(hdr);
    fire(7'h44);
    chk("irq", 1'h1, irq);
    apb(APB_IRQ_STAT, 1'h1, 32'h1);
    chk("irq clear", 1'h0, irq);
    // Second logged error must not overwrite; masked meanwhile
    apb(APB_IRQ_MASK, 1'h1, 32'h0);
    hdr = ~hdr;
    fire(7'h48);
    chk("masked irq", 1'h0, irq);
    chk("first kept", ~hdr, hlog);
    apb(APB_IRQ_MASK, 1'h1, 32'h1);
    chk("unmasked irq", 1'h1, irq);
    apb(APB_IRQ_STAT, 1'h1, 32'h1);
    // Every error kind on its own
    expSeen = 6'h0C;
    for (int k = 0; k < 6; k++) begin
      expSeen[k] = 1'h1;
      fire(7'(1 << k));
      chk("errorSeen", expSeen, seen);
    end
    // Low power held off while a completion is pending
    apb(APB_CTRL, 1'h1, 32'h1);
    @(posedge clock);
    lowPowerReq <= 1'h1;
    repeat (5) @(negedge clock);
    chk("lp held", 1'h0, lpAct);
    apb(APB_CTRL, 1'h1, 32'h0);
    for (int i = 0; i < 9 && lpAct !== 1'h1; i++) @(negedge clock);
    chk("lp entered", 1'h1, lpAct);
    chk("errorCount", 6'h08, cnt);
    chk("ctrl slave", 1'h1, ctrlSl);
    chk("soft log", ~hdr, hlogX1);
    chk("x8 lanes", 6'h0E, seenX8);
    chk("log notes", '0, HDR_W'(expQ.size()));
    summarize();
  end
endmodule
